// [logic/cpu_clock_pkg.sv]
// Purpose: Shared constants for the CPU clock source switch
// Assumes: 100 MHz system clock, 4-bit register port
// Notes: Bit positions follow the oscillator control word

package cpu_clock_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 4;
    localparam logic [15:0] OSC_CTRL_ADDR = 16'hFF00;
    localparam int CLK_SEL_BIT = 3;
    localparam int FAST_EN_BIT = 2;
    localparam int UNUSED_BIT = 1;
    localparam int VOLT_SEL_BIT = 0;
    localparam logic CLK_SEL_RST = 1'h0;
    localparam logic FAST_EN_RST = 1'h0;
    localparam logic VOLT_SEL_RST = 1'h0;
    localparam logic [3:0] RDATA_RST = 4'h0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOW_CYCLE_NS = 61000;
    localparam int FAST_CYCLE_NS = 500;
    localparam int SLOW_CYCLE_CYC = SLOW_CYCLE_NS / CLK_PERIOD_NS;
    localparam int FAST_CYCLE_CYC = FAST_CYCLE_NS / CLK_PERIOD_NS;
    localparam int STALL_CYC_DEF = 2 * SLOW_CYCLE_CYC;
    localparam int STALL_W = 14;
    localparam logic [1:0] INSTR_MIN_CYCLES = 2'h1;

endpackage : cpu_clock_pkg

// [logic/level_sync2.sv]
// Purpose: Two-stage synchroniser for asynchronous levels
// Assumes: Inputs are slow or tolerate one cycle of skew
// Notes: Async reset clears both stages

`timescale 1ns/1ns

module level_sync2 #(
    parameter int W = 1
) (
    input wire logic clk, // Sampling clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [W-1:0] d, // Asynchronous input
    output logic [W-1:0] q // Synchronised output
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sync_st_t;

    sync_st_t st_r;
    sync_st_t st_nxt;

    // First stage feeds only the second
    always_comb begin
        st_nxt.meta = d;
        st_nxt.q = st_r.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;

endmodule : level_sync2

// [logic/clock_glitch_free_mux.sv]
// Purpose: Glitch-free switch between two sampled oscillator levels
// Assumes: Oscillator levels already synchronised to clk
// Notes: Output parks low between sources

`timescale 1ns/1ns

module clock_glitch_free_mux (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic slow_lvl, // Slow oscillator level
    input wire logic fast_lvl, // Fast oscillator level
    input wire logic sel_fast, // Requested source
    output logic cpu_clk, // Muxed CPU clock level
    output logic cpu_edge, // Pulse on CPU clock rise
    output logic on_fast // Fast source in use
);
    typedef enum logic [2:0] {
        RUN_SLOW, DRAIN_SLOW, ARM_FAST, RUN_FAST, DRAIN_FAST, ARM_SLOW
    } mux_state_t;

    typedef struct packed {
        mux_state_t state;
        logic clk;
        logic edge_p;
    } mux_st_t;

    mux_st_t st_r;
    mux_st_t st_nxt;

    // ----------------------------------------
    // Switch sequence
    // ----------------------------------------
    // Old source is left only while low, new one joined only while low
    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            RUN_SLOW: if (sel_fast) st_nxt.state = DRAIN_SLOW;
            DRAIN_SLOW: begin
                if (!sel_fast) st_nxt.state = RUN_SLOW;
                else if (!slow_lvl) st_nxt.state = ARM_FAST;
            end
            // A dropped request turns back while still parked low
            ARM_FAST: begin
                if (!sel_fast) st_nxt.state = ARM_SLOW;
                else if (!fast_lvl) st_nxt.state = RUN_FAST;
            end
            RUN_FAST: if (!sel_fast) st_nxt.state = DRAIN_FAST;
            DRAIN_FAST: begin
                if (sel_fast) st_nxt.state = RUN_FAST;
                else if (!fast_lvl) st_nxt.state = ARM_SLOW;
            end
            ARM_SLOW: begin
                if (sel_fast) st_nxt.state = ARM_FAST;
                else if (!slow_lvl) st_nxt.state = RUN_SLOW;
            end
            default: st_nxt.state = RUN_SLOW;
        endcase
        case (st_nxt.state)
            RUN_SLOW, DRAIN_SLOW: st_nxt.clk = slow_lvl;
            RUN_FAST, DRAIN_FAST: st_nxt.clk = fast_lvl;
            default: st_nxt.clk = 1'b0;
        endcase
        st_nxt.edge_p = st_nxt.clk & ~st_r.clk;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{state: RUN_SLOW, clk: 1'b0, edge_p: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cpu_clk = st_r.clk;
    assign cpu_edge = st_r.edge_p;
    assign on_fast = (st_r.state == RUN_FAST) || (st_r.state == DRAIN_FAST);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    park_low_a: assert property ((st_r.state == ARM_FAST) || (st_r.state == ARM_SLOW) |-> !st_r.clk)
        else $error("clock not parked low while arming");
    no_high_drop_a: assert property ($changed(on_fast) |-> !st_r.clk)
        else $error("source changed during a high phase");

endmodule : clock_glitch_free_mux

// [logic/cpu_clock_source_switch.sv]
// Purpose: CPU clock source, fast oscillator gate and core level control
// Assumes: Oscillator pins are sampled levels; bus is a plain strobe port
// Notes: Slow oscillator type is fixed by a build parameter

`timescale 1ns/1ns

module cpu_clock_source_switch
    import cpu_clock_pkg::*;
#(
    parameter bit SLOW_IS_CR = 1'b0,
    parameter int STALL_CYC = cpu_clock_pkg::STALL_CYC_DEF
) (
    input wire logic clk_sys, // 100 MHz system clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [cpu_clock_pkg::ADDR_W-1:0] reg_addr, // Register address
    input wire logic [cpu_clock_pkg::DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [cpu_clock_pkg::DATA_W-1:0] reg_rdata, // Read data, next cycle
    input wire logic slow_osc_in, // Slow oscillator pin
    input wire logic fast_osc_in, // Fast oscillator pin
    output logic fast_osc_run, // Fast oscillator enable
    output logic core_supply_high, // Core level request, 1 = 2.2 V
    output logic cpu_clk, // CPU clock level
    output logic cpu_edge, // Pulse per CPU clock rise
    output logic cpu_on_fast, // Fast source in use
    input wire logic instr_start, // Start an instruction
    input wire logic [1:0] instr_cycles, // Instruction length, 1..3
    output logic instr_busy, // Instruction in progress
    output logic instr_done, // Pulse at instruction end
    output logic clock_stalled // No CPU clock edge for too long
);
    import cpu_clock_pkg::*;

    localparam logic [STALL_W-1:0] STALL_LIMIT = STALL_W'(STALL_CYC);

    typedef struct packed {
        logic clk_sel;
        logic fast_en;
        logic volt_sel;
        logic [DATA_W-1:0] rdata;
        logic [1:0] instr_left;
        logic instr_done;
        logic [STALL_W-1:0] stall_cnt;
        logic stalled;
    } ctrl_st_t;

    ctrl_st_t st_r;
    ctrl_st_t st_nxt;

    logic rst_s;
    logic [1:0] osc_lvl;
    logic wr_hit;
    logic rd_hit;
    logic volt_eff;
    logic sel_block;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a == OSC_CTRL_ADDR);
    endfunction : addr_hit

    // Unused bit has no storage
    function automatic logic [DATA_W-1:0] pack_ctrl(input logic c, input logic f, input logic v);
        logic [DATA_W-1:0] w;
        w = '0;
        w[CLK_SEL_BIT] = c;
        w[FAST_EN_BIT] = f;
        w[UNUSED_BIT] = 1'b0;
        w[VOLT_SEL_BIT] = v;
        pack_ctrl = w;
    endfunction : pack_ctrl

    // ----------------------------------------
    // Reset release and pin sampling
    // ----------------------------------------
    level_sync2 #(.W(1)) u_rst_sync (
        .clk(clk_sys),
        .rst_n(reset_n),
        .d(1'b1),
        .q(rst_s)
    );

    level_sync2 #(.W(2)) u_osc_sync (
        .clk(clk_sys),
        .rst_n(rst_s),
        .d({fast_osc_in, slow_osc_in}),
        .q(osc_lvl)
    );

    // ----------------------------------------
    // Clock source switch
    // ----------------------------------------
    clock_glitch_free_mux u_mux (
        .clk(clk_sys),
        .rst_n(rst_s),
        .slow_lvl(osc_lvl[0]),
        .fast_lvl(osc_lvl[1]),
        .sel_fast(st_r.clk_sel),
        .cpu_clk(cpu_clk),
        .cpu_edge(cpu_edge),
        .on_fast(cpu_on_fast)
    );

    // ----------------------------------------
    // Control logic
    // ----------------------------------------
    assign wr_hit = reg_wr && addr_hit(reg_addr);
    assign rd_hit = reg_rd && addr_hit(reg_addr);

    // Build-time type: CR treats the voltage select as always high
    assign volt_eff = SLOW_IS_CR ? 1'b1 : reg_wdata[VOLT_SEL_BIT];
    // Judged on the values this same write leaves behind
    assign sel_block = !volt_eff && !reg_wdata[FAST_EN_BIT];

    always_comb begin
        st_nxt = st_r;
        st_nxt.instr_done = 1'b0;

        if (wr_hit) begin
            st_nxt.fast_en = reg_wdata[FAST_EN_BIT];
            st_nxt.volt_sel = reg_wdata[VOLT_SEL_BIT];
            st_nxt.clk_sel = reg_wdata[CLK_SEL_BIT] && !sel_block;
        end

        st_nxt.rdata = rd_hit ? pack_ctrl(st_r.clk_sel, st_r.fast_en, st_r.volt_sel) : RDATA_RST;

        // Instruction length counted in CPU clock rises
        if (st_r.instr_left == 2'h0) begin
            if (instr_start) begin
                st_nxt.instr_left = (instr_cycles == 2'h0) ? INSTR_MIN_CYCLES : instr_cycles;
            end
        end else if (cpu_edge) begin
            st_nxt.instr_left = st_r.instr_left - 2'h1;
            st_nxt.instr_done = (st_r.instr_left == 2'h1);
        end

        // Dead-source watch; a stopped fast clock shows up here
        if (cpu_edge) begin
            st_nxt.stall_cnt = '0;
            st_nxt.stalled = 1'b0;
        end else if (st_r.stall_cnt == STALL_LIMIT) begin
            st_nxt.stalled = 1'b1;
        end else begin
            st_nxt.stall_cnt = st_r.stall_cnt + STALL_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_s) begin
        if (!rst_s) begin
            st_r <= '{clk_sel: CLK_SEL_RST, fast_en: FAST_EN_RST, volt_sel: VOLT_SEL_RST,
                      rdata: RDATA_RST, instr_left: 2'h0, instr_done: 1'b0,
                      stall_cnt: '0, stalled: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata = st_r.rdata;
    assign fast_osc_run = st_r.fast_en;
    // CR slow oscillator needs the high level at all times
    assign core_supply_high = SLOW_IS_CR ? 1'b1 : st_r.volt_sel;
    assign instr_busy = (st_r.instr_left != 2'h0);
    assign instr_done = st_r.instr_done;
    assign clock_stalled = st_r.stalled;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_s);

    sel_follows_a: assert property ($rose(st_r.clk_sel) && fast_osc_run ##1 fast_osc_run [*8]
        |-> ##[0:400] cpu_on_fast || !st_r.clk_sel || !fast_osc_run)
        else $error("fast source not taken after select");
    sel_readback_a: assert property (rd_hit |=> reg_rdata[CLK_SEL_BIT] == $past(st_r.clk_sel))
        else $error("select bit read back wrong");
    write_refused_a: assert property (wr_hit && !SLOW_IS_CR && !st_r.clk_sel && !cpu_on_fast
        && !reg_wdata[VOLT_SEL_BIT] && !reg_wdata[FAST_EN_BIT] |=> !st_r.clk_sel && !cpu_on_fast [*2])
        else $error("blocked select write took effect");
    fast_enable_a: assert property (wr_hit |=> fast_osc_run == $past(reg_wdata[FAST_EN_BIT]))
        else $error("fast enable does not follow write");
    volt_xtal_a: assert property (wr_hit && !SLOW_IS_CR |=> core_supply_high == $past(reg_wdata[VOLT_SEL_BIT]))
        else $error("core level does not follow select");
    volt_cr_a: assert property (SLOW_IS_CR |-> core_supply_high)
        else $error("core level dropped in CR mode");
    cr_no_block_a: assert property (wr_hit && SLOW_IS_CR && reg_wdata[CLK_SEL_BIT] |=> st_r.clk_sel)
        else $error("CR mode blocked the select");
    unused_bit_a: assert property (reg_rd ##1 1'b1 |-> reg_rdata[UNUSED_BIT] == 1'b0)
        else $error("unused bit read as one");
    instr_end_a: assert property (instr_done |-> $past(cpu_edge) && !instr_busy)
        else $error("instruction ended without a clock rise");
    instr_three_a: assert property (instr_busy && cpu_edge && (st_r.instr_left != 2'h1)
        |=> instr_busy && !instr_done)
        else $error("instruction ended before its last clock rise");
    instr_start_a: assert property (!instr_busy && instr_start |=> instr_busy)
        else $error("accepted instruction not busy");
    sel_hold_a: assert property (!wr_hit |=> $stable(st_r.clk_sel))
        else $error("select changed without a write");
    enable_hold_a: assert property (!wr_hit |=> $stable(fast_osc_run))
        else $error("fast enable changed without a write");
    level_hold_a: assert property (!wr_hit |=> $stable(core_supply_high))
        else $error("core level changed without a write");
    unmapped_read_a: assert property (reg_rd && !rd_hit |=> reg_rdata == RDATA_RST)
        else $error("unmapped read returned data");

    to_fast_c: cover property ($rose(cpu_on_fast));
    to_slow_c: cover property ($fell(cpu_on_fast));
    refused_c: cover property (wr_hit && reg_wdata[CLK_SEL_BIT] && sel_block);
    instr_c: cover property (instr_done && cpu_on_fast);

endmodule : cpu_clock_source_switch

// [bench/cpu_clock_source_switch_bench.sv]
// Purpose: Self-checking bench for the CPU clock source switch
// Assumes: Oscillator pins toggled from clk_sys at scaled rates
// Notes: Second instance built with the CR slow oscillator option

`timescale 1ns/1ns

module cpu_clock_source_switch_bench;
    import cpu_clock_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [3:0] reg_wdata = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic slow_osc_in = 1'b0;
    logic fast_osc_in = 1'b0;
    logic instr_start = 1'b0;
    logic [1:0] instr_cycles = 2'h1;
    logic [3:0] reg_rdata, rdata_cr;
    logic fast_osc_run, core_supply_high, cpu_clk, cpu_edge, cpu_on_fast;
    logic instr_busy, instr_done, clock_stalled, supply_cr, on_fast_cr;
    logic slow_run = 1'b1;
    int miscompares = 0;
    int tests_run = 0;
    int seed = 45461;
    int slow_cnt = 0;
    int fast_cnt = 0;
    logic [3:0] got, got_cr, w;

    cpu_clock_source_switch #(.SLOW_IS_CR(1'b0), .STALL_CYC(200)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .slow_osc_in(slow_osc_in), .fast_osc_in(fast_osc_in), .fast_osc_run(fast_osc_run),
        .core_supply_high(core_supply_high), .cpu_clk(cpu_clk), .cpu_edge(cpu_edge), .cpu_on_fast(cpu_on_fast),
        .instr_start(instr_start), .instr_cycles(instr_cycles), .instr_busy(instr_busy),
        .instr_done(instr_done), .clock_stalled(clock_stalled));

    cpu_clock_source_switch #(.SLOW_IS_CR(1'b1), .STALL_CYC(200)) dut_cr (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_cr),
        .slow_osc_in(slow_osc_in), .fast_osc_in(fast_osc_in), .fast_osc_run(),
        .core_supply_high(supply_cr), .cpu_clk(), .cpu_edge(), .cpu_on_fast(on_fast_cr),
        .instr_start(instr_start), .instr_cycles(instr_cycles), .instr_busy(), .instr_done(), .clock_stalled());

    // ----------------------------------------
    // Clock and scaled oscillators
    // ----------------------------------------
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // Slow period 40 cycles, fast period 4; real ratios would make the run far too long
    always @(posedge clk_sys) begin
        slow_cnt <= (slow_cnt == 19) ? 0 : slow_cnt + 1;
        if (slow_cnt == 19 && slow_run) slow_osc_in <= ~slow_osc_in;
        fast_cnt <= (fast_cnt == 1) ? 0 : fast_cnt + 1;
        // Stopped fast oscillator rests low, as a gated one would
        if (fast_osc_run !== 1'b1) fast_osc_in <= 1'b0;
        else if (fast_cnt == 1) fast_osc_in <= ~fast_osc_in;
    end

    // ----------------------------------------
    // Tasks and expectation functions
    // ----------------------------------------
    function automatic logic [3:0] exp_xtal(input logic [3:0] d);
        exp_xtal = d & 4'hD;
        if (!d[2] && !d[0]) exp_xtal[3] = 1'b0;
    endfunction : exp_xtal

    task automatic report_bad(input string msg);
        miscompares++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask : report_bad

    task automatic chk_word(input logic [3:0] g, input logic [3:0] e);
        tests_run++;
        if (g !== e) report_bad($sformatf("word got %h expected %h", g, e));
    endtask : chk_word

    task automatic chk_bit(input logic g, input logic e);
        tests_run++;
        if (g !== e) report_bad($sformatf("bit got %b expected %b", g, e));
    endtask : chk_bit

    task automatic chk_count(input int g, input int e);
        tests_run++;
        if (g != e) report_bad($sformatf("count got %0d expected %0d", g, e));
    endtask : chk_count

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : do_reset

    task automatic bus_write(input logic [15:0] a, input logic [3:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : bus_write

    task automatic bus_read(input logic [15:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        got = reg_rdata;
        got_cr = rdata_cr;
    endtask : bus_read

    task automatic wait_fast(input logic e, input logic e_cr);
        int n;
        n = 0;
        while ((cpu_on_fast !== e || on_fast_cr !== e_cr) && n < 300) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk_bit(cpu_on_fast, e);
        chk_bit(on_fast_cr, e_cr);
    endtask : wait_fast

    // Counts CPU edges between an accepted start and its done pulse
    task automatic run_instr(input logic [1:0] c);
        int edges, n;
        edges = 0;
        n = 0;
        @(posedge clk_sys);
        instr_start <= 1'b1;
        instr_cycles <= c;
        @(posedge clk_sys);
        instr_start <= 1'b0;
        while (n < 400) begin
            @(negedge clk_sys);
            n++;
            if (n == 1) chk_bit(instr_busy, 1'b1);
            if (instr_done === 1'b1) break;
            if (cpu_edge === 1'b1) edges++;
        end
        chk_bit(instr_done, 1'b1);
        chk_bit(instr_busy, 1'b0);
        chk_count(edges, (c == 2'h0) ? 1 : int'(c));
    endtask : run_instr

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        #400000;
        miscompares++;
        final_report();
    end

    initial begin
        do_reset();
        bus_read(OSC_CTRL_ADDR);
        chk_word(got, 4'h0);
        chk_bit(supply_cr, 1'b1);
        bus_write(OSC_CTRL_ADDR, 4'hF);
        chk_bit(fast_osc_run, 1'b1);
        chk_bit(core_supply_high, 1'b1);
        bus_read(OSC_CTRL_ADDR);
        chk_word(got, 4'hD);
        bus_write(OSC_CTRL_ADDR, 4'h8);
        chk_bit(core_supply_high, 1'b0);
        chk_bit(supply_cr, 1'b1);
        bus_read(OSC_CTRL_ADDR);
        chk_word(got, 4'h0);
        chk_word(got_cr, 4'h8);
        wait_fast(1'b0, 1'b1);
        for (int i = 0; i < 40; i++) begin
            w = 4'($random(seed));
            bus_write(OSC_CTRL_ADDR, w);
            chk_bit(fast_osc_run, w[2]);
            chk_bit(core_supply_high, w[0]);
            bus_read(OSC_CTRL_ADDR);
            chk_word(got, exp_xtal(w));
            chk_word(got_cr, w & 4'hD);
            bus_read(16'($random(seed)) | 16'h0001);
            chk_word(got, 4'h0);
        end
        // Software sequence into the fast clock, then back out in separate writes
        bus_write(OSC_CTRL_ADDR, 4'h1);
        bus_write(OSC_CTRL_ADDR, 4'h5);
        bus_write(OSC_CTRL_ADDR, 4'hD);
        wait_fast(1'b1, 1'b1);
        for (int c = 0; c < 4; c++) run_instr(2'(c));
        bus_write(OSC_CTRL_ADDR, 4'h5);
        wait_fast(1'b0, 1'b0);
        bus_write(OSC_CTRL_ADDR, 4'h1);
        bus_write(OSC_CTRL_ADDR, 4'h0);
        chk_bit(core_supply_high, 1'b0);
        for (int c = 1; c < 4; c++) run_instr(2'(c));
        // Stop the slow source to see the stall flag, then let it recover
        slow_run <= 1'b0;
        repeat (300) @(posedge clk_sys);
        #1;
        chk_bit(clock_stalled, 1'b1);
        chk_bit(cpu_clk, slow_osc_in);
        slow_run <= 1'b1;
        repeat (100) @(posedge clk_sys);
        #1;
        chk_bit(clock_stalled, 1'b0);
        // Second reset in mid-run clears the control bits again
        bus_write(OSC_CTRL_ADDR, 4'hD);
        do_reset();
        bus_read(OSC_CTRL_ADDR);
        chk_word(got, 4'h0);
        chk_bit(fast_osc_run, 1'b0);
        final_report();
    end

endmodule : cpu_clock_source_switch_bench
